// >>> tdc_defs.svh
`ifndef TDC_DEFS_SVH
`define TDC_DEFS_SVH
// ==========================================================
// Buffer geometry
`define BUF_SIZE    16'd2000
`define BUF_LAST    16'd1999
`define VIS_SIZE    16'd1920
`define LINE_W      16'd80
`define ATTR_BIT    7
// ==========================================================
// Command byte: device field high nibble, operation low
`define OP_RD_REGS  4'h1
`define OP_RD_LINE  4'h2
`define OP_RD_DEVID 4'h3
`define OP_RD_LIM   4'h4
`define OP_RD_IMM   4'h5
`define OP_WR_CTL   4'h6
`define OP_WDLC     4'h7
`define OP_RD_DATA  4'h8
`define OP_WR_IMM   4'h9
`define OP_WR_DATA  4'ha
`define OP_ACT_WR   4'hb
`define CMD_RD08    8'h08
`define CMD_RD18    8'h18
`define DEV_BASE    4'h0
`define DEV_MODEL   4'h4
`define DEV_KBD     4'h5
`define DEV_IND     4'h6
`define DEV_MSR     4'h7
// ==========================================================
// Lengths and data byte fields
`define REGS_LEN    16'd6
`define MSR_LEN     16'd16
`define ID_LEN      16'd1
`define WDLC_MIN    8'h01
`define WDLC_MAX    8'h0e
`define CTL_RST_EXC 12
`define CTL_MORE    8
// ==========================================================
// Register offsets
`define A_CTRL      8'h00
`define A_AC        8'h04
`define A_RC        8'h08
`define A_CUR       8'h0c
`define A_STAT      8'h10
`define A_CTLB      8'h14
`define A_IND       8'h18
`define A_WEND      8'h1c
`define CTRL_RST    1'b1
`define RESP_OK     2'h0
`define RESP_ERR    2'h2
`endif

// >>> tdc_pkg.sv
package tdc_pkg;
    typedef struct packed {
        logic       cmd;
        logic [7:0] data;
    } tdc_rx_t;
    typedef enum logic [1:0] {
        EXC_NONE, EXC_INVREG, EXC_ATTR, EXC_STORE
    } tdc_exc_t;
    typedef enum logic [3:0] {
        ST_IDLE, ST_ARG, ST_SRCH, ST_SEND, ST_CTL1,
        ST_CTL2, ST_WDLC, ST_WDLN, ST_WACT
    } tdc_st_t;
endpackage : tdc_pkg

// >>> tdc_cmd_exec.sv
`timescale 1ns/1ps
`include "tdc_defs.svh"
// ==========================================================
// Function
// - Buffer holds 2000 bytes, positions 0..1999
// - Read registers returns address, cursor, reference
// - Read line sends to line end
// - Read line checks visible range first
// - Device ID decoded, unknown gives zero
// - Stripe feature read data: sixteen zeros
// - Read data 08h returns one byte
// - Read data 08h range error posts exception
// - Read data 18h counts bytes before sending
// - Read data 18h leaves counter past end
// - Read data 18h: no attribute before buffer end gives exception
// - Read limits sends address-to-reference area
// - Read limits validates counters, else exception
// - Read limits leaves address at reference+1
// - Read immediate validates address, finds end
// - Armed write stores activate data, records end
// - Write immediate validates address, then arms
// - Write data checks counter, arms start
// - Write control stores byte, may clear exception
// - Bit 8 brings second control byte
// - Load-cursor first byte 01..0Eh is count
// - Store advances counter, overflow posts exception
// - Cursor takes address counter at end
// - Indicator byte stored, transitions recorded
module tdc_cmd_exec #(
    parameter logic [7:0] ID_BASE  = 8'h21, // Arbitrary value
    parameter logic [7:0] ID_KBD   = 8'h42, // Arbitrary value
    parameter logic [7:0] ID_MODEL = 8'h63  // Arbitrary value
) (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            awvalid,
    output logic                 awready,
    input  wire logic [7:0]      awaddr,
    input  wire logic            wvalid,
    output logic                 wready,
    input  wire logic [31:0]     wdata,
    input  wire logic [3:0]      wstrb,
    output logic                 bvalid,
    input  wire logic            bready,
    output logic [1:0]           bresp,
    input  wire logic            arvalid,
    output logic                 arready,
    input  wire logic [7:0]      araddr,
    output logic                 rvalid,
    input  wire logic            rready,
    output logic [31:0]          rdata,
    output logic [1:0]           rresp,
    input  wire logic            rx_valid,
    input  wire tdc_pkg::tdc_rx_t rx,
    output logic                 rx_ready,
    output logic                 tx_valid,
    output logic [7:0]           tx_data,
    input  wire logic            tx_ready
);
    import tdc_pkg::*;

    tdc_st_t     st_r;
    tdc_exc_t    exc_r;
    logic [7:0]  mem [0:`BUF_SIZE-16'd1];
    logic [15:0] ac_r, rc_r, cur_r, ptr_r, sc_r;
    logic [15:0] start_r, wend_r, cnt_r, arg_r;
    logic [47:0] sh_r;
    logic [7:0]  ctl1_r, ctl2_r, ind_r, trans_r, n_r, awa_r;
    logic [31:0] wd_r;
    logic [3:0]  ws_r, dev_r;
    logic        src_buf_r, armed_r, en_r, rd18_r, imm_rd_r;
    logic        aw_ok_r, w_ok_r;
    logic        acc, wr_go;
    logic [3:0]  op;
    logic [15:0] arg_full, w16;

    assign acc      = rx_valid && rx_ready;
    assign op       = rx.data[3:0];
    assign arg_full = {arg_r[7:0], rx.data};
    assign w16      = {rx.data, 8'h00};
    assign wr_go    = aw_ok_r && w_ok_r && !bvalid;

    function automatic logic in_buf(input logic [15:0] a);
        return a <= `BUF_LAST;
    endfunction : in_buf

    function automatic logic [15:0] line_end(input logic [15:0] a);
        return a - (a % `LINE_W) + `LINE_W - 16'd1;
    endfunction : line_end

    function automatic logic [7:0] dev_id(input logic [3:0] d);
        case (d)
            `DEV_BASE:  return ID_BASE;
            `DEV_KBD:   return ID_KBD;
            `DEV_MODEL: return ID_MODEL;
            default:    return 8'h00;
        endcase
    endfunction : dev_id

    function automatic logic [15:0] merge(input logic [15:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  s);
        logic [15:0] r;
        r = o;
        for (int i = 0; i < 2; i++) begin
            if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
        end
        return r;
    endfunction : merge

    function automatic logic hit(input logic [7:0] a);
        return a[1:0] == 2'b00 && a <= `A_WEND;
    endfunction : hit

    // ==========================================================
    // Byte intake; one idle cycle after each byte taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_ready <= 1'b0;
        end else if (acc) begin
            rx_ready <= 1'b0;
        end else begin
            rx_ready <= en_r && st_r != ST_SEND && st_r != ST_SRCH;
        end
    end

    // ==========================================================
    // Command execution and counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r      <= ST_IDLE;
            exc_r     <= EXC_NONE;
            ac_r      <= 16'h0000;
            rc_r      <= 16'h0000;
            cur_r     <= 16'h0000;
            ptr_r     <= 16'h0000;
            sc_r      <= 16'h0000;
            start_r   <= 16'h0000;
            wend_r    <= 16'h0000;
            cnt_r     <= 16'h0000;
            arg_r     <= 16'h0000;
            sh_r      <= 48'h0;
            ctl1_r    <= 8'h00;
            ctl2_r    <= 8'h00;
            ind_r     <= 8'h00;
            trans_r   <= 8'h00;
            n_r       <= 8'h00;
            dev_r     <= 4'h0;
            src_buf_r <= 1'b0;
            armed_r   <= 1'b0;
            rd18_r    <= 1'b0;
            imm_rd_r  <= 1'b0;
            en_r      <= `CTRL_RST;
            tx_valid  <= 1'b0;
            tx_data   <= 8'h00;
        end else begin
            // A command byte always starts a new command
            if (acc && rx.cmd) begin
                dev_r <= rx.data[7:4];
                st_r  <= ST_IDLE;
                case (op)
                    `OP_RD_REGS: begin
                        sh_r      <= {ac_r, cur_r, rc_r};
                        cnt_r     <= `REGS_LEN;
                        src_buf_r <= 1'b0;
                        st_r      <= ST_SEND;
                    end
                    `OP_RD_LINE: begin
                        if (ac_r >= `VIS_SIZE) begin
                            exc_r <= EXC_INVREG;
                        end else begin
                            ptr_r     <= ac_r;
                            cnt_r     <= line_end(ac_r) - ac_r + 16'd1;
                            ac_r      <= line_end(ac_r);
                            src_buf_r <= 1'b1;
                            st_r      <= ST_SEND;
                        end
                    end
                    `OP_RD_DEVID: begin
                        sh_r      <= {dev_id(rx.data[7:4]), 40'h0};
                        cnt_r     <= `ID_LEN;
                        src_buf_r <= 1'b0;
                        st_r      <= ST_SEND;
                    end
                    `OP_RD_DATA: begin
                        if (rx.data == `CMD_RD08) begin
                            if (!in_buf(ac_r)) begin
                                exc_r <= EXC_INVREG;
                            end else begin
                                ptr_r     <= ac_r;
                                cnt_r     <= `ID_LEN;
                                src_buf_r <= 1'b1;
                                st_r      <= ST_SEND;
                            end
                        end else if (rx.data == `CMD_RD18) begin
                            if (!in_buf(ac_r)) begin
                                exc_r <= EXC_INVREG;
                            end else begin
                                ptr_r  <= ac_r;
                                sc_r   <= ac_r;
                                rd18_r <= 1'b1;
                                st_r   <= ST_SRCH;
                            end
                        end else begin
                            sh_r      <= 48'h0;
                            cnt_r     <= (rx.data[7:4] == `DEV_MSR) ?
                                         `MSR_LEN : `ID_LEN;
                            src_buf_r <= 1'b0;
                            st_r      <= ST_SEND;
                        end
                    end
                    `OP_RD_LIM: begin
                        if (!in_buf(ac_r) || !in_buf(rc_r) || rc_r < ac_r) begin
                            exc_r <= EXC_INVREG;
                        end else begin
                            ptr_r     <= ac_r;
                            cnt_r     <= rc_r - ac_r + 16'd1;
                            ac_r      <= rc_r + 16'd1;
                            src_buf_r <= 1'b1;
                            st_r      <= ST_SEND;
                        end
                    end
                    `OP_RD_IMM, `OP_WR_IMM: begin
                        imm_rd_r <= op == `OP_RD_IMM;
                        n_r      <= 8'h02;
                        st_r     <= ST_ARG;
                    end
                    `OP_WR_CTL: st_r <= ST_CTL1;
                    `OP_WDLC:   st_r <= ST_WDLC;
                    `OP_WR_DATA: begin
                        if (in_buf(ac_r)) begin
                            start_r <= ac_r;
                            armed_r <= 1'b1;
                        end else begin
                            exc_r <= EXC_INVREG;
                        end
                    end
                    `OP_ACT_WR: begin
                        if (armed_r) begin
                            ptr_r   <= start_r;
                            wend_r  <= start_r;
                            armed_r <= 1'b0;
                            st_r    <= ST_WACT;
                        end
                    end
                    default: st_r <= ST_IDLE;
                endcase
            end else begin
                case (st_r)
                    ST_ARG: begin
                        if (acc) begin
                            arg_r <= arg_full;
                            n_r   <= n_r - 8'h01;
                            if (n_r == 8'h01) begin
                                st_r <= ST_IDLE;
                                if (!in_buf(arg_full)) begin
                                    exc_r <= EXC_INVREG;
                                end else if (imm_rd_r) begin
                                    ptr_r  <= arg_full;
                                    sc_r   <= arg_full;
                                    rd18_r <= 1'b0;
                                    st_r   <= ST_SRCH;
                                end else begin
                                    start_r <= arg_full;
                                    armed_r <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_SRCH: begin
                        // End found before any byte goes out
                        if (mem[sc_r[10:0]][`ATTR_BIT] ||
                            sc_r == `BUF_LAST) begin
                            cnt_r     <= sc_r - ptr_r + 16'd1;
                            src_buf_r <= 1'b1;
                            st_r      <= ST_SEND;
                            if (rd18_r) ac_r <= sc_r + 16'd1;
                            if (rd18_r && !mem[sc_r[10:0]][`ATTR_BIT])
                                exc_r <= EXC_ATTR;
                        end else begin
                            sc_r <= sc_r + 16'd1;
                        end
                    end
                    ST_SEND: begin
                        if (!tx_valid || tx_ready) begin
                            if (cnt_r != 16'h0000) begin
                                tx_valid <= 1'b1;
                                tx_data  <= src_buf_r ?
                                            mem[ptr_r[10:0]] : sh_r[47:40];
                                ptr_r    <= ptr_r + 16'd1;
                                sh_r     <= {sh_r[39:0], 8'h00};
                                cnt_r    <= cnt_r - 16'd1;
                            end else begin
                                tx_valid <= 1'b0;
                                st_r     <= ST_IDLE;
                            end
                        end
                    end
                    ST_CTL1: begin
                        if (acc) begin
                            ctl1_r <= rx.data;
                            if (w16[`CTL_RST_EXC]) exc_r <= EXC_NONE;
                            st_r <= w16[`CTL_MORE] ? ST_CTL2 : ST_IDLE;
                        end
                    end
                    ST_CTL2: begin
                        if (acc) begin
                            ctl2_r <= rx.data;
                            st_r   <= ST_IDLE;
                        end
                    end
                    ST_WDLC, ST_WDLN: begin
                        if (acc) begin
                            n_r  <= n_r - 8'h01;
                            st_r <= ST_IDLE;
                            if (st_r == ST_WDLC && dev_r == `DEV_IND) begin
                                ind_r   <= rx.data;
                                trans_r <= {ind_r[3:0] & ~rx.data[3:0],
                                            ~ind_r[3:0] & rx.data[3:0]};
                            end else if (st_r == ST_WDLC &&
                                         rx.data >= `WDLC_MIN &&
                                         rx.data <= `WDLC_MAX) begin
                                n_r  <= rx.data;
                                st_r <= ST_WDLN;
                            end else if (!in_buf(ac_r)) begin
                                exc_r <= EXC_STORE;
                                cur_r <= ac_r;
                            end else begin
                                mem[ac_r[10:0]] <= rx.data;
                                ac_r  <= ac_r + 16'd1;
                                cur_r <= ac_r + 16'd1;
                                if (st_r == ST_WDLN && n_r != 8'h01)
                                    st_r <= ST_WDLN;
                            end
                        end
                    end
                    ST_WACT: begin
                        if (acc) begin
                            if (in_buf(ptr_r)) begin
                                mem[ptr_r[10:0]] <= rx.data;
                                wend_r <= ptr_r;
                                ptr_r  <= ptr_r + 16'd1;
                            end else begin
                                exc_r <= EXC_STORE;
                            end
                        end
                    end
                    default: st_r <= ST_IDLE;
                endcase
            end
            // Software writes land last, so they win a tie
            if (wr_go) begin
                case (awa_r)
                    `A_CTRL: if (ws_r[0]) en_r <= wd_r[0];
                    `A_AC:   ac_r <= merge(ac_r, wd_r, ws_r);
                    `A_RC:   rc_r <= merge(rc_r, wd_r, ws_r);
                    `A_CUR:  cur_r <= merge(cur_r, wd_r, ws_r);
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // Register bus write side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            aw_ok_r <= 1'b0;
            w_ok_r  <= 1'b0;
            awa_r   <= 8'h00;
            wd_r    <= 32'h0;
            ws_r    <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OK;
        end else begin
            if (awvalid && awready) begin
                awa_r   <= awaddr;
                aw_ok_r <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wd_r   <= wdata;
                ws_r   <= wstrb;
                w_ok_r <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_go) begin
                bvalid  <= 1'b1;
                bresp   <= hit(awa_r) ? `RESP_OK : `RESP_ERR;
                aw_ok_r <= 1'b0;
                w_ok_r  <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Register bus read side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= `RESP_OK;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= hit(araddr) ? `RESP_OK : `RESP_ERR;
            case (araddr)
                `A_CTRL: rdata <= {31'h0, en_r};
                `A_AC:   rdata <= {16'h0, ac_r};
                `A_RC:   rdata <= {16'h0, rc_r};
                `A_CUR:  rdata <= {16'h0, cur_r};
                `A_STAT: rdata <= {25'h0, st_r, armed_r, exc_r};
                `A_CTLB: rdata <= {16'h0, ctl2_r, ctl1_r};
                `A_IND:  rdata <= {16'h0, trans_r, ind_r};
                `A_WEND: rdata <= {16'h0, wend_r};
                default: rdata <= 32'h0;
            endcase
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_cmd(logic [3:0] o);
        acc && rx.cmd && op == o && !wr_go;
    endsequence

    a_regs_reply: assert property (s_cmd(`OP_RD_REGS) |=>
        cnt_r == `REGS_LEN &&
        sh_r == {$past(ac_r), $past(cur_r), $past(rc_r)})
        else $error("read registers reply wrong");
    a_regs_first: assert property (s_cmd(`OP_RD_REGS) |->
        ##2 tx_valid && tx_data == $past(ac_r[15:8], 2))
        else $error("address high byte not first");
    a_line_range: assert property (
        s_cmd(`OP_RD_LINE) ##0 ac_r >= `VIS_SIZE |=>
        exc_r == EXC_INVREG && st_r == ST_IDLE)
        else $error("read line range not checked");
    a_stripe_zero: assert property (
        s_cmd(`OP_RD_DATA) ##0 rx.data[7:4] == `DEV_MSR |=>
        cnt_r == `MSR_LEN && sh_r == 48'h0)
        else $error("stripe reply not sixteen zeros");
    a_rd08_range: assert property (
        s_cmd(`OP_RD_DATA) ##0 rx.data == `CMD_RD08 ##0 !in_buf(ac_r)
        |=> exc_r == EXC_INVREG)
        else $error("read data range not checked");
    a_attr_end: assert property (
        st_r == ST_SRCH && rd18_r && sc_r == `BUF_LAST &&
        !mem[sc_r[10:0]][`ATTR_BIT] |=> exc_r == EXC_ATTR)
        else $error("missing attribute exception");
    a_lim_bad: assert property (
        s_cmd(`OP_RD_LIM) ##0 rc_r < ac_r |=>
        exc_r == EXC_INVREG && st_r == ST_IDLE)
        else $error("read limits order not checked");
    a_lim_ac: assert property (
        s_cmd(`OP_RD_LIM) ##0 in_buf(rc_r) && rc_r >= ac_r |=>
        ac_r == $past(rc_r) + 16'd1 && st_r == ST_SEND)
        else $error("address not reference plus one");
    a_wdlc_cur: assert property (
        st_r == ST_WDLN && acc && !rx.cmd && n_r == 8'h01 && !wr_go
        |=> cur_r == ac_r)
        else $error("cursor not loaded at end");
endmodule : tdc_cmd_exec

// >>> tdc_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host controller: sends bytes, takes replies with stalls
module tdc_host_model (
    input  wire logic        aclk,
    output logic             rx_valid,
    output tdc_pkg::tdc_rx_t rx,
    input  wire logic        rx_ready,
    input  wire logic        tx_valid,
    input  wire logic [7:0]  tx_data,
    output logic             tx_ready
);
    logic [8:0] q[$];
    logic [7:0] got[$];
    int         seed = 86;
    initial {rx_valid, rx, tx_ready} = '0;
    // Idle lane toggles so a stale byte never passes for a new one
    always @(posedge aclk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        tx_ready <= 1'($random(seed));
        if (rx_valid && rx_ready) void'(q.pop_front());
        rx_valid <= q.size() != 0;
        rx <= q.size() != 0 ? q[0] : ~rx;
    end
endmodule : tdc_host_model

// >>> twinax_display_read_write_cmds_tb_top.sv
`timescale 1ns/1ps
module twinax_display_read_write_cmds_tb_top;
    import tdc_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, tx_ready;
    logic        rx_valid, rx_ready, tx_valid;
    logic [7:0]  awaddr, araddr, tx_data, d[3];
    logic [31:0] wdata, rdata;
    logic [15:0] s;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp;
    tdc_rx_t     rx;
    int          failures, checks_done, n, seed = 86;
    tdc_cmd_exec u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .rx_valid(rx_valid), .rx(rx), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    tdc_host_model u_host (.aclk(aclk), .rx_valid(rx_valid), .rx(rx),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready));
    initial forever #10 aclk = ~aclk;
    initial #1200000 finish_test(1);
    // ==========================================================
    // Checks and bus tasks
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        checks_done++;
        failures += int'(g !== e);
        if (g !== e) $display("Error at %0t: got %h want %h", $time, g, e);
    endtask : chk
    // Read uses v as a mask, write as data
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] v, input logic [33:0] e);
        @(posedge aclk);
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        {awaddr, araddr, wdata} <= {a, a, v};
        do begin
            @(posedge aclk);
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
            arvalid <= arvalid && !arready;
        end while (w ? !bvalid : !rvalid);
        {bready, rready} <= 2'b0;
        chk(w ? {bresp, 32'h0} : {rresp, rdata & v}, e);
    endtask : bus
    task automatic xfer(input logic [8:0] b[$], input logic [127:0] e,
                        input int k);
        foreach (b[i]) u_host.q.push_back(b[i]);
        do @(posedge aclk);
        while (u_host.q.size() != 0 || u_host.got.size() < k);
        for (int i = 0; i < k; i++)
            chk(34'(u_host.got[i]), 34'(e[8*(k-1-i) +: 8]));
        u_host.got.delete();
    endtask : xfer
    function automatic logic [47:0] regs_img(input logic [15:0] a, c, r);
        return {a, c, r};
    endfunction : regs_img
    task automatic finish_test(input int late);
        failures += late;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // ==========================================================
    // Stimulus
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        bus(0, 8'h20, '1, {2'h2, 32'h0});
        for (n = 0; n < 3; n++) begin
            s = 16'($unsigned($random(seed)) % 1990);
            foreach (d[i]) d[i] = 8'($random(seed)) & 8'h7f;
            d[2][7] = 1'b1;
            bus(1, 8'h04, 32'(s), 0);
            bus(1, 8'h0c, 32'(s + 16'd1), 0);
            bus(1, 8'h08, 32'(s + 16'd2), 0);
            xfer('{9'h101}, regs_img(s, s + 16'd1, s + 16'd2), 6);
            xfer('{9'h109, {1'b0, s[15:8]}, {1'b0, s[7:0]}, 9'h10b,
                   {1'b0, d[0]}, {1'b0, d[1]}, {1'b0, d[2]}}, 0, 0);
            xfer('{9'h105, {1'b0, s[15:8]}, {1'b0, s[7:0]}},
                 {d[0], d[1], d[2]}, 3);
            bus(1, 8'h04, 32'(s), 0);
            xfer('{9'h104}, {d[0], d[1], d[2]}, 3);
            bus(0, 8'h04, 32'hffff, 34'(s + 16'd3));
            xfer('{9'h104}, 0, 0);
            bus(0, 8'h10, 32'h3, 34'h1);
            xfer('{9'h106, 9'h011, 9'h05a}, 0, 0);
            bus(0, 8'h14, 32'hffff, 34'h5a11);
            bus(0, 8'h10, 32'h3, 34'h0);
            xfer('{9'h178}, 0, 16);
            $display("Loop %0d done", n);
        end
        // ==========================================================
        // Corner cases near the screen and buffer ends, then device ID, indicator and armed write
        bus(1, 8'h04, 32'd1917, 0);
        xfer('{9'h107, 9'h003, 9'h041, 9'h042, 9'h0c3}, 0, 0);
        bus(0, 8'h0c, 32'hffff, 34'd1920);
        xfer('{9'h102}, 0, 0);
        bus(0, 8'h10, 32'h3, 34'h1);
        bus(1, 8'h04, 32'd1917, 0);
        xfer('{9'h102}, 24'h4142c3, 3);
        bus(0, 8'h04, 32'hffff, 34'd1919);
        bus(1, 8'h04, 32'd1917, 0);
        xfer('{9'h108, 9'h118}, 32'h414142c3, 4);
        bus(0, 8'h04, 32'hffff, 34'd1920);
        bus(1, 8'h04, 32'd1999, 0);
        xfer('{9'h107, 9'h020, 9'h107, 9'h021}, 0, 0);
        bus(0, 8'h10, 32'h3, 34'h3);
        bus(1, 8'h04, 32'd1999, 0);
        xfer('{9'h118}, 8'h20, 1);
        bus(0, 8'h10, 32'h3, 34'h2);
        xfer('{9'h108}, 0, 0);
        bus(0, 8'h10, 32'h3, 34'h1);
        xfer('{9'h103, 9'h123}, {u_dut.ID_BASE, 8'h00}, 2);
        xfer('{9'h167, 9'h005, 9'h167, 9'h003}, 0, 0);
        bus(0, 8'h18, 32'hffff, 34'h4203);
        bus(1, 8'h04, 32'd10, 0);
        xfer('{9'h10a, 9'h10b, 9'h077, 9'h108}, 8'h77, 1);
        bus(0, 8'h1c, 32'hffff, 34'd10);
        $display("Corner cases done");
        finish_test(0);
    end
endmodule : twinax_display_read_write_cmds_tb_top
